// ==== include/acrl_pkg.sv ====
// Purpose: shared constants and types for the acquisition control register
// Assumes: 20 MHz ref_clk
// Notes:   field positions are MSB first, channel select down to coding
package acrl_pkg;
	localparam int          CTRL_W        = 6;
	localparam int          CHAN_W        = 3;
	localparam logic [2:0]  SER_BITS      = 3'h6;
	localparam int          REF_PERIOD_NS = 50;
	localparam int          SETTLE_NS     = 400;
	localparam int          SETTLE_CYC    = (SETTLE_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	localparam logic [3:0]  SETTLE_LOAD   = 4'(SETTLE_CYC);
	localparam logic [5:0]  CTRL_RESET    = 6'h00;

	typedef struct packed {
		logic [CHAN_W-1:0] channel_select;
		logic              soft_convert_enable;
		logic              soft_standby;
		logic              coding_twos;
	} acrl_ctrl_type;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SETTLE = 2'b01
	} acrl_state_type;
endpackage : acrl_pkg

// ==== rtl/acrl_serial_rx.sv ====
// Purpose: serial write frame receiver on the serial clock
// Assumes: frame sync and data change away from the falling clock edge
// Notes:   hands finished words over with a toggle; word stays stable
`timescale 1ns/1ps
module acrl_serial_rx
	import acrl_pkg::*;
(
	input  wire logic              sclk,
	input  wire logic              rst_b,
	input  wire logic              write_frame_sync_b,
	input  wire logic              serial_data,
	output logic [CTRL_W-1:0]      word_ff,
	output logic                   done_tgl_ff
);
	logic [2:0]        bit_cnt_ff;
	logic [CTRL_W-2:0] shift_ff;
	logic              frame_rst_b;

	// Clock stops between frames, so the inactive frame sync itself clears the count
	assign frame_rst_b = rst_b & ~write_frame_sync_b;

	always_ff @(negedge sclk or negedge frame_rst_b) begin
		if (!frame_rst_b) begin
			bit_cnt_ff <= 3'h0;
		end else if (bit_cnt_ff < SER_BITS) begin
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
		end
	end

	always_ff @(negedge sclk or negedge rst_b) begin
		if (!rst_b) begin
			shift_ff <= 5'h00;
		end else if (bit_cnt_ff < SER_BITS) begin
			shift_ff <= {shift_ff[CTRL_W-3:0], serial_data};
		end
	end

	always_ff @(negedge sclk or negedge rst_b) begin
		if (!rst_b) begin
			word_ff     <= CTRL_RESET;
			done_tgl_ff <= 1'b0;
		end else if (!write_frame_sync_b && bit_cnt_ff == SER_BITS - 3'h1) begin
			word_ff     <= {shift_ff, serial_data};
			done_tgl_ff <= ~done_tgl_ff;
		end
	end

	cnt_limit_a: assert property (
		@(negedge sclk) disable iff (!frame_rst_b)
		bit_cnt_ff <= SER_BITS)
		else $error("serial bit count past six");
	// Plain compare, so the unset history before the first edge cannot trip it
	tgl_sixth_a: assert property (
		@(negedge sclk) disable iff (!rst_b)
		done_tgl_ff != $past(done_tgl_ff) |-> $past(bit_cnt_ff) == 3'h5)
		else $error("word handed over at wrong bit");
endmodule : acrl_serial_rx

// ==== rtl/adc_control_register_load.sv ====
// Purpose: acquisition control register with parallel and serial load
// Assumes: mode pin high selects parallel, low selects serial
// Notes:   convert_start is a one-cycle ref_clk pulse to the converter
`timescale 1ns/1ps
module adc_control_register_load
	import acrl_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst_b,
	input  wire logic              parallel_mode,
	input  wire logic              chip_select_b,
	input  wire logic              write_strobe_b,
	input  wire logic [CTRL_W-1:0] data_lines,
	input  wire logic              sclk,
	input  wire logic              write_frame_sync_b,
	input  wire logic              serial_data,
	output acrl_ctrl_type          ctrl_ff,
	output logic                   twos_complement_ff,
	output logic                   settling_ff,
	output logic                   convert_start_ff
);
	logic [1:0]        mode_sync_ff;
	logic [1:0]        cs_sync_ff;
	logic [1:0]        wr_sync_ff;
	logic [CTRL_W-1:0] data_sync1_ff;
	logic [CTRL_W-1:0] data_sync2_ff;
	logic [CTRL_W-1:0] data_hold_ff;
	logic              wr_prev_ff;
	logic [1:0]        fs_sync_ff;
	logic              fs_prev_ff;
	logic [1:0]        tgl_sync_ff;
	logic              tgl_prev_ff;
	logic              frame_done_ff;
	logic [CTRL_W-1:0] ser_word;
	logic              ser_tgl;
	logic              par_write;
	logic              ser_write;
	logic              ser_abort;
	logic              any_write;
	logic [3:0]        settle_cnt_ff;
	acrl_state_type    state_ff;

	acrl_serial_rx u_rx (
		.sclk               (sclk),
		.rst_b              (rst_b),
		.write_frame_sync_b (write_frame_sync_b),
		.serial_data        (serial_data),
		.word_ff            (ser_word),
		.done_tgl_ff        (ser_tgl)
	);

	// Pin synchronisers; first stages feed only second stages
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_sync_ff  <= 2'h0;
			cs_sync_ff    <= 2'h3;
			wr_sync_ff    <= 2'h3;
			fs_sync_ff    <= 2'h3;
			tgl_sync_ff   <= 2'h0;
			data_sync1_ff <= 6'h00;
			data_sync2_ff <= 6'h00;
		end else begin
			mode_sync_ff  <= {mode_sync_ff[0], parallel_mode};
			cs_sync_ff    <= {cs_sync_ff[0], chip_select_b};
			wr_sync_ff    <= {wr_sync_ff[0], write_strobe_b};
			fs_sync_ff    <= {fs_sync_ff[0], write_frame_sync_b};
			tgl_sync_ff   <= {tgl_sync_ff[0], ser_tgl};
			data_sync1_ff <= data_lines;
			data_sync2_ff <= data_sync1_ff;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_prev_ff  <= 1'b1;
			fs_prev_ff  <= 1'b1;
			tgl_prev_ff <= 1'b0;
		end else begin
			wr_prev_ff  <= wr_sync_ff[1];
			fs_prev_ff  <= fs_sync_ff[1];
			tgl_prev_ff <= tgl_sync_ff[1];
		end
	end

	// Data held while strobe is low so the rising edge sees settled lines
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			data_hold_ff <= 6'h00;
		end else if (!wr_sync_ff[1] && !cs_sync_ff[1]) begin
			data_hold_ff <= data_sync2_ff;
		end
	end

	assign par_write = mode_sync_ff[1] && wr_sync_ff[1] && !wr_prev_ff && !cs_sync_ff[1];
	assign ser_write = !mode_sync_ff[1] && (tgl_sync_ff[1] != tgl_prev_ff);
	assign ser_abort = !mode_sync_ff[1] && fs_sync_ff[1] && !fs_prev_ff && !frame_done_ff;
	assign any_write = par_write || ser_write;

	// Set by a finished word wins over the clear at the next frame start
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			frame_done_ff <= 1'b0;
		end else if (ser_write) begin
			frame_done_ff <= 1'b1;
		end else if (!fs_sync_ff[1] && fs_prev_ff) begin
			frame_done_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_ff <= acrl_ctrl_type'(CTRL_RESET);
		end else if (par_write) begin
			ctrl_ff <= acrl_ctrl_type'(data_hold_ff);
		end else if (ser_write) begin
			ctrl_ff <= acrl_ctrl_type'(ser_word);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			twos_complement_ff <= 1'b0;
		end else begin
			twos_complement_ff <= ctrl_ff.coding_twos;
		end
	end

	// An aborted frame restarts the settling pulse; enable is still the old value
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff      <= ST_IDLE;
			settle_cnt_ff <= 4'h0;
		end else if (any_write || ser_abort) begin
			state_ff      <= ST_SETTLE;
			settle_cnt_ff <= SETTLE_LOAD;
		end else begin
			case (state_ff)
				ST_SETTLE: begin
					settle_cnt_ff <= settle_cnt_ff - 4'h1;
					if (settle_cnt_ff == 4'h1) begin
						state_ff <= ST_IDLE;
					end
				end
				default: begin
					state_ff      <= ST_IDLE;
					settle_cnt_ff <= 4'h0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			settling_ff      <= 1'b0;
			convert_start_ff <= 1'b0;
		end else begin
			settling_ff      <= (state_ff == ST_SETTLE);
			convert_start_ff <= (state_ff == ST_SETTLE) && (settle_cnt_ff == 4'h1)
				&& !any_write && !ser_abort && ctrl_ff.soft_convert_enable;
		end
	end

	ctrl_hold_a: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		!par_write && !ser_write |=> $stable(ctrl_ff))
		else $error("register changed without write");
	par_load_a: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		par_write |=> ctrl_ff == $past(data_hold_ff))
		else $error("parallel load wrong");
	ser_load_a: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		ser_write && !par_write |=> ctrl_ff == $past(ser_word))
		else $error("serial load wrong");
	abort_conv_a: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		ser_abort && ctrl_ff.soft_convert_enable && !any_write
		##1 (!any_write && !ser_abort) [*8] |=> convert_start_ff)
		else $error("aborted frame did not convert");
	settle_len_a: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		any_write |=> state_ff == ST_SETTLE && settle_cnt_ff == SETTLE_LOAD)
		else $error("settling pulse not started");
	no_conv_a: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		convert_start_ff |-> $past(ctrl_ff.soft_convert_enable))
		else $error("convert without enable");
	conv_pulse_a: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		convert_start_ff |=> !convert_start_ff)
		else $error("convert pulse too long");
	coding_a: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		##1 twos_complement_ff == $past(ctrl_ff.coding_twos))
		else $error("coding output wrong");
	reset_zero_a: assert property (
		@(posedge ref_clk)
		$rose(rst_b) |-> ctrl_ff == acrl_ctrl_type'(CTRL_RESET))
		else $error("reset not zero");
endmodule : adc_control_register_load

// ==== dv/acrl_host_model.sv ====
// Purpose: host side model that sends serial write frames
// Assumes: sclk period 160 ns, clock idles high outside frames
// Notes:   released data line shows the inverse of the last bit
`timescale 1ns/1ps
module acrl_host_model (
	output logic sclk,
	output logic write_frame_sync_b,
	output logic serial_data
);
	initial begin
		sclk               = 1'b1;
		write_frame_sync_b = 1'b1;
		serial_data        = 1'b0;
	end
	// Bits past the sixth carry junk so that ignoring them is visible
	task automatic send(input logic [5:0] word, input int nclk);
		#37 write_frame_sync_b = 1'b0;
		for (int i = 0; i < nclk; i++) begin
			serial_data = (i < 6) ? word[5-i] : ~serial_data;
			#80 sclk = 1'b0;
			#80 sclk = 1'b1;
		end
		#200 write_frame_sync_b = 1'b1;
		serial_data = ~serial_data;
	endtask : send
endmodule : acrl_host_model

// ==== dv/test_adc_control_register_load.sv ====
// Purpose: self-checking bench for the acquisition control register
// Assumes: settle length SETTLE_CYC, convert pulse on its last cycle
// Notes:   observation runs beside each write so the whole pulse is seen
`timescale 1ns/1ps
module test_adc_control_register_load;
	import acrl_pkg::*;
	logic              ref_clk, rst_b, parallel_mode, chip_select_b, write_strobe_b;
	logic [CTRL_W-1:0] data_lines;
	logic              sclk, write_frame_sync_b, serial_data;
	logic              twos_complement_ff, settling_ff, convert_start_ff;
	acrl_ctrl_type     ctrl_ff;
	int                mismatches, samples_checked, cycles;

	adc_control_register_load uut (.ref_clk(ref_clk), .rst_b(rst_b),
		.parallel_mode(parallel_mode), .chip_select_b(chip_select_b),
		.write_strobe_b(write_strobe_b), .data_lines(data_lines), .sclk(sclk),
		.write_frame_sync_b(write_frame_sync_b), .serial_data(serial_data),
		.ctrl_ff(ctrl_ff), .twos_complement_ff(twos_complement_ff),
		.settling_ff(settling_ff), .convert_start_ff(convert_start_ff));
	acrl_host_model host (.sclk(sclk), .write_frame_sync_b(write_frame_sync_b),
		.serial_data(serial_data));

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic give_verdict;
		if (mismatches == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	task automatic check(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask : check

	// Watches a fixed window so a missing or extra pulse is counted
	task automatic obs(input logic [5:0] exp, input int conv, input int nset);
		int n = 0;
		int s = 0;
		repeat (45) begin
			@(posedge ref_clk);
			#1;
			n += (convert_start_ff === 1'b1);
			s += (settling_ff === 1'b1);
		end
		check(ctrl_ff === exp, "register value");
		check(twos_complement_ff === exp[0], "coding copy");
		check(n == conv, "convert pulse count");
		check(s == nset, "settle length");
	endtask : obs

	task automatic pwr(input logic [5:0] d, input logic cs_b);
		@(posedge ref_clk);
		#1 chip_select_b = cs_b;
		write_strobe_b = 1'b0;
		data_lines = d;
		repeat (4) @(posedge ref_clk);
		#1 write_strobe_b = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1 chip_select_b = 1'b1;
		data_lines = ~d;
	endtask : pwr

	task automatic t_reset;
		check(ctrl_ff === CTRL_RESET && settling_ff === 1'b0, "reset state");
		repeat (3) @(posedge ref_clk);
	endtask : t_reset

	task automatic t_parallel;
		fork pwr(6'h2d, 1'b0); obs(6'h2d, 1, SETTLE_CYC); join
		fork pwr(6'h2a, 1'b0); obs(6'h2a, 0, SETTLE_CYC); join
		fork pwr(6'h15, 1'b1); obs(6'h2a, 0, 0); join
	endtask : t_parallel

	task automatic t_serial;
		@(posedge ref_clk);
		#1 parallel_mode = 1'b0;
		repeat (4) @(posedge ref_clk);
		fork host.send(6'h17, 6); obs(6'h17, 1, SETTLE_CYC); join
		fork host.send(6'h22, 9); obs(6'h22, 0, SETTLE_CYC); join
		fork pwr(6'h3f, 1'b0); obs(6'h22, 0, 0); join
	endtask : t_serial

	task automatic t_abort;
		// Aborted frames still restart the settling pulse
		fork host.send(6'h3f, 3); obs(6'h22, 0, SETTLE_CYC); join
		fork host.send(6'h1c, 6); obs(6'h1c, 1, SETTLE_CYC); join
		fork host.send(6'h00, 5); obs(6'h1c, 1, SETTLE_CYC); join
	endtask : t_abort

	initial begin
		rst_b = 1'b0;
		parallel_mode = 1'b1;
		chip_select_b = 1'b1;
		write_strobe_b = 1'b1;
		data_lines = 6'h00;
		repeat (8) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		t_reset();
		t_parallel();
		t_serial();
		t_abort();
		give_verdict();
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			give_verdict();
		end
	end
endmodule : test_adc_control_register_load
